/* core/lsb_pkg.sv */
// constants and carrier types for the lan sram shared bus interface
package lsb_pkg;

    localparam int CLK_PERIOD_NS  = 8;
    localparam int SRAM_ADDR_BITS = 13;
    localparam int BUS_BITS       = 16;
    localparam int TIMER_BITS     = 8;

    // least times, each rounded up to whole clock cycles
    localparam int ALE_OPEN_NS    = 16;
    localparam int ALE_HOLD_NS    = 8;
    localparam int STROBE_NS      = 70;
    localparam int DATA_HOLD_NS   = 8;
    localparam int NET_RESET_NS   = 1000;
    localparam int STRAP_NS       = 200;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ALE_OPEN_CYC  = ns_to_cyc(ALE_OPEN_NS);
    localparam int ALE_HOLD_CYC  = ns_to_cyc(ALE_HOLD_NS);
    localparam int STROBE_CYC    = ns_to_cyc(STROBE_NS);
    localparam int DATA_HOLD_CYC = ns_to_cyc(DATA_HOLD_NS);
    localparam int NET_RESET_CYC = ns_to_cyc(NET_RESET_NS);
    localparam int STRAP_CYC     = ns_to_cyc(STRAP_NS);

    // host interrupt lines cover levels 6 down to 3
    localparam int IRQ_LINES     = 4;
    localparam int IRQ_SEL_BITS  = 2;

    localparam logic [BUS_BITS-1:0] BUS_ZERO = 16'h0000;

    // host request to the sram
    typedef struct packed {
        logic                      wr;
        logic                      sel_hi_n;
        logic                      sel_lo_n;
        logic [SRAM_ADDR_BITS-1:0] addr;
        logic [BUS_BITS-1:0]       data;
    } lsb_sram_req_type;

    // host request to the controller as local bus slave
    typedef struct packed {
        logic                wr;
        logic [BUS_BITS-1:0] addr;
        logic [BUS_BITS-1:0] data;
    } lsb_ctl_req_type;

    // levels caught at power-up
    typedef struct packed {
        logic valid;
        logic thin_lan;
        logic lan_enabled;
    } lsb_strap_type;

endpackage

/* core/lsb_strap_capture.sv */
// power-up strap sampling of the sram upper select and controller ale pins
`timescale 1ns/1ns
module lsb_strap_capture
    import lsb_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          reset,
    input  wire logic          sel_upper_in,
    input  wire logic          ale_in,
    output logic               probing,
    output lsb_strap_type      straps
);

    logic [TIMER_BITS-1:0] cnt_ff;
    lsb_strap_type         straps_ff;

    wire window_done = (cnt_ff == TIMER_BITS'(STRAP_CYC - 1));

    // pins are caught after release so that pull resistors have settled
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_ff    <= '0;
            straps_ff <= '0;
        end else if (!straps_ff.valid) begin
            cnt_ff <= cnt_ff + TIMER_BITS'(1);
            if (window_done) begin
                straps_ff.valid       <= 1'b1;
                straps_ff.thin_lan    <= sel_upper_in;
                straps_ff.lan_enabled <= ale_in;
            end
        end
    end

    assign probing = !straps_ff.valid;
    assign straps  = straps_ff;

endmodule

/* core/lsb_irq_route.sv */
// controller interrupt status and host interrupt level steering
`timescale 1ns/1ns
module lsb_irq_route
    import lsb_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    input  wire logic                    net_irq_n,
    input  wire logic                    lan_on,
    input  wire logic                    irq_enable,
    input  wire logic [IRQ_SEL_BITS-1:0] irq_level,
    output logic                         irq_status,
    output logic [IRQ_LINES-1:0]         host_irq_n
);

    logic                 status_ff;
    logic [IRQ_LINES-1:0] lines_n_ff;

    wire                 irq_live  = lan_on && !net_irq_n;
    wire [IRQ_LINES-1:0] level_hot = IRQ_LINES'(1) << irq_level;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_ff  <= 1'b0;
            lines_n_ff <= '1;
        end else begin
            status_ff  <= irq_live;
            lines_n_ff <= (irq_live && irq_enable) ? ~level_hot : '1;
        end
    end

    assign irq_status = status_ff;
    assign host_irq_n = lines_n_ff;

endmodule

/* core/lsb_shared_bus.sv */
// shared sram arbiter and controller local bus interface
`timescale 1ns/1ns
module lsb_shared_bus
    import lsb_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic                      backplane_reset,
    input  wire logic                      lan_reg1_wr,
    input  wire logic                      host_req,
    input  wire lsb_sram_req_type          host_cmd,
    output logic                           host_ack,
    output logic [BUS_BITS-1:0]            host_rdata,
    input  wire logic                      ctl_req,
    input  wire lsb_ctl_req_type           ctl_cmd,
    output logic                           ctl_ack,
    output logic [BUS_BITS-1:0]            ctl_rdata,
    input  wire logic                      irq_enable,
    input  wire logic [IRQ_SEL_BITS-1:0]   irq_level,
    output logic [IRQ_LINES-1:0]           host_irq_n,
    output logic                           net_irq_status,
    output logic                           thin_lan,
    output logic                           lan_enabled,
    output logic                           straps_valid,
    input  wire logic [BUS_BITS-1:0]       sram_ad_in,
    output logic [BUS_BITS-1:0]            sram_ad_out,
    output logic                           sram_ad_oe_n,
    input  wire logic                      sram_sel_upper_in,
    output logic                           sram_sel_upper_n,
    output logic                           sram_sel_upper_oe_n,
    output logic                           sram_sel_lower_n,
    output logic                           sram_write_n,
    output logic                           sram_output_en_n,
    output logic                           sram_addr_latch_en,
    output logic                           net_reset_n,
    input  wire logic                      net_bus_request_n,
    output logic                           net_bus_grant_n,
    input  wire logic                      net_addr_latch_en,
    input  wire logic                      net_byte_mask_hi_n,
    input  wire logic                      net_byte_mask_lo_n,
    input  wire logic                      net_irq_n,
    input  wire logic [BUS_BITS-1:0]       lad_in,
    output logic [BUS_BITS-1:0]            lad_out,
    output logic                           lad_oe_n,
    input  wire logic                      net_read_in,
    output logic                           net_read_out,
    output logic                           net_read_oe_n,
    input  wire logic                      controller_data_strobe_n_in,
    output logic                           controller_data_strobe_n_out,
    output logic                           controller_data_strobe_n_oe_n,
    input  wire logic                      net_bus_drive_en_n_in,
    output logic                           net_bus_drive_en_n_out,
    output logic                           net_bus_drive_en_n_oe_n,
    input  wire logic                      net_ready_n_in,
    output logic                           net_ready_n_out,
    output logic                           net_ready_n_oe_n
);

    typedef enum logic [2:0] {SR_IDLE, SR_ADDR, SR_HOLD, SR_STROBE, SR_END} lsb_sr_type;
    typedef enum logic [1:0] {SL_IDLE, SL_ADDR, SL_DATA, SL_DONE} lsb_sl_type;

    lsb_sr_type            sr_ff, nxt_sr;
    lsb_sl_type            sl_ff, nxt_sl;
    logic [TIMER_BITS-1:0] sr_tmr_ff, nxt_sr_tmr;
    logic [TIMER_BITS-1:0] sl_tmr_ff, nxt_sl_tmr;
    logic [TIMER_BITS-1:0] rst_cnt_ff;
    lsb_sram_req_type      cur_ff;
    lsb_ctl_req_type       sl_cmd_ff;
    logic                  owner_net_ff;
    logic                  grant_ff;
    logic                  ale_s1_ff, ale_s2_ff, ale_s3_ff;
    logic [SRAM_ADDR_BITS-1:0] net_addr_ff;
    logic                  net_pend_ff;
    logic                  net_rdy_ff;
    logic                  net_rd_ff;
    logic [BUS_BITS-1:0]   sram_ad_ff;
    logic [BUS_BITS-1:0]   lad_ff;
    logic [BUS_BITS-1:0]   host_rdata_ff;
    logic [BUS_BITS-1:0]   ctl_rdata_ff;
    logic                  probing;
    lsb_strap_type         straps;

    lsb_strap_capture u_strap (
        .core_clk     (core_clk),
        .reset        (reset),
        .sel_upper_in (sram_sel_upper_in),
        .ale_in       (net_addr_latch_en),
        .probing      (probing),
        .straps       (straps)
    );

    // controller reset is stretched so it always meets the chip's minimum width
    wire lan_rst_req = reset || backplane_reset || lan_reg1_wr;
    wire lan_rst     = (rst_cnt_ff != '0);
    wire lan_on      = straps.valid && straps.lan_enabled;
    wire lan_off     = lan_rst || !lan_on;

    lsb_irq_route u_irq (
        .core_clk   (core_clk),
        .reset      (reset),
        .net_irq_n  (net_irq_n),
        .lan_on     (lan_on),
        .irq_enable (irq_enable),
        .irq_level  (irq_level),
        .irq_status (net_irq_status),
        .host_irq_n (host_irq_n)
    );

    always_ff @(posedge core_clk) begin
        if (lan_rst_req) begin
            rst_cnt_ff <= TIMER_BITS'(NET_RESET_CYC);
        end else if (lan_rst) begin
            rst_cnt_ff <= rst_cnt_ff - TIMER_BITS'(1);
        end
    end

    // controller ale is asynchronous to us: two flops before the fall detector looks at it; the address latch uses the raw pin
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ale_s1_ff <= 1'b1;
            ale_s2_ff <= 1'b1;
            ale_s3_ff <= 1'b1;
        end else begin
            ale_s1_ff <= net_addr_latch_en;
            ale_s2_ff <= ale_s1_ff;
            ale_s3_ff <= ale_s2_ff;
        end
    end

    wire ale_fall = ale_s3_ff && !ale_s2_ff;

    // grant waits for an idle slave transfer, then holds until request drops
    always_ff @(posedge core_clk) begin
        if (reset || lan_off) begin
            grant_ff <= 1'b0;
        end else if (net_bus_request_n) begin
            grant_ff <= 1'b0;
        end else if (sl_ff == SL_IDLE) begin
            grant_ff <= 1'b1;
        end
    end

    // loaded every cycle while granted and ale is high, held once it falls
    always_ff @(posedge core_clk) begin
        if (reset) begin
            net_addr_ff <= '0;
        end else if (grant_ff && net_addr_latch_en) begin
            net_addr_ff <= lad_in[SRAM_ADDR_BITS-1:0];
        end
    end

    wire sr_idle   = (sr_ff == SR_IDLE);
    wire take_net  = sr_idle && net_pend_ff && grant_ff;
    wire take_host = sr_idle && host_req && !take_net;
    wire sr_done   = (sr_ff == SR_END);
    wire sr_tmr_0  = (sr_tmr_ff == '0);

    always_ff @(posedge core_clk) begin
        if (reset || lan_off) begin
            net_pend_ff <= 1'b0;
        end else if (grant_ff && ale_fall) begin
            net_pend_ff <= 1'b1;
        end else if (take_net) begin
            net_pend_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_sr     = sr_ff;
        nxt_sr_tmr = sr_tmr_ff;
        if (!sr_tmr_0) begin
            nxt_sr_tmr = sr_tmr_ff - TIMER_BITS'(1);
        end
        case (sr_ff)
            SR_IDLE: begin
                if (take_net || take_host) begin
                    nxt_sr     = SR_ADDR;
                    nxt_sr_tmr = TIMER_BITS'(ALE_OPEN_CYC - 1);
                end
            end
            SR_ADDR: begin
                if (sr_tmr_0) begin
                    nxt_sr     = SR_HOLD;
                    nxt_sr_tmr = TIMER_BITS'(ALE_HOLD_CYC - 1);
                end
            end
            SR_HOLD: begin
                if (sr_tmr_0) begin
                    nxt_sr     = SR_STROBE;
                    nxt_sr_tmr = TIMER_BITS'(STROBE_CYC - 1);
                end
            end
            SR_STROBE: begin
                if (sr_tmr_0) begin
                    nxt_sr     = SR_END;
                    nxt_sr_tmr = TIMER_BITS'(DATA_HOLD_CYC - 1);
                end
            end
            SR_END: begin
                if (sr_tmr_0) begin
                    nxt_sr = SR_IDLE;
                end
            end
            default: begin
                nxt_sr = SR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sr_ff     <= SR_IDLE;
            sr_tmr_ff <= '0;
        end else begin
            sr_ff     <= nxt_sr;
            sr_tmr_ff <= nxt_sr_tmr;
        end
    end

    // controller write data is on the bus by the time the synchronised ale fall lands
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cur_ff       <= '0;
            owner_net_ff <= 1'b0;
            net_rd_ff    <= 1'b0;
        end else if (take_net) begin
            cur_ff.wr    <= !net_read_in;
            cur_ff.addr  <= net_addr_ff;
            cur_ff.data  <= lad_in;
            owner_net_ff <= 1'b1;
            net_rd_ff    <= net_read_in;
        end else if (take_host) begin
            cur_ff       <= host_cmd;
            owner_net_ff <= 1'b0;
        end
    end

    wire sr_strobe  = (sr_ff == SR_STROBE);
    wire sr_wr_data = cur_ff.wr && (sr_strobe || sr_done);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sram_ad_ff <= BUS_ZERO;
        end else if (take_net) begin
            sram_ad_ff <= BUS_BITS'(net_addr_ff);
        end else if (take_host) begin
            sram_ad_ff <= BUS_BITS'(host_cmd.addr);
        end else if (sr_ff == SR_HOLD && nxt_sr == SR_STROBE) begin
            sram_ad_ff <= cur_ff.data;
        end
    end

    // read data taken on the last edge with output enable low
    wire sr_rd_last = sr_strobe && sr_tmr_0 && !cur_ff.wr;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_rdata_ff <= BUS_ZERO;
        end else if (sr_rd_last && !owner_net_ff) begin
            host_rdata_ff <= sram_ad_in;
        end
    end

    assign sram_ad_out        = sram_ad_ff;
    assign sram_ad_oe_n       = !((sr_ff == SR_ADDR) || (sr_ff == SR_HOLD) || sr_wr_data);
    assign sram_addr_latch_en = (sr_ff == SR_ADDR);
    assign sram_write_n       = !(sr_strobe && cur_ff.wr);
    assign sram_output_en_n   = !(sr_strobe && !cur_ff.wr);

    // selects are a plain mux, so byte masks reach the sram with no clock delay
    wire sel_active = !sr_idle;
    wire sel_hi_n   = owner_net_ff ? net_byte_mask_hi_n : cur_ff.sel_hi_n;
    wire sel_lo_n   = owner_net_ff ? net_byte_mask_lo_n : cur_ff.sel_lo_n;
    assign sram_sel_upper_n    = !sel_active || sel_hi_n;
    assign sram_sel_lower_n    = !sel_active || sel_lo_n;
    assign sram_sel_upper_oe_n = probing;

    assign host_ack   = sr_done && sr_tmr_0 && !owner_net_ff;
    assign host_rdata = host_rdata_ff;

    // ready stays low until the controller opens its latch for the next address
    always_ff @(posedge core_clk) begin
        if (reset || lan_off || !grant_ff) begin
            net_rdy_ff <= 1'b0;
        end else if (sr_done && owner_net_ff) begin
            net_rdy_ff <= 1'b1;
        end else if (ale_s2_ff) begin
            net_rdy_ff <= 1'b0;
        end
    end

    wire sl_idle  = (sl_ff == SL_IDLE);
    wire sl_take  = sl_idle && ctl_req && !grant_ff && !lan_off && net_bus_request_n;
    wire sl_tmr_0 = (sl_tmr_ff == '0);

    always_comb begin
        nxt_sl     = sl_ff;
        nxt_sl_tmr = sl_tmr_ff;
        if (!sl_tmr_0) begin
            nxt_sl_tmr = sl_tmr_ff - TIMER_BITS'(1);
        end
        case (sl_ff)
            SL_IDLE: begin
                if (sl_take) begin
                    nxt_sl     = SL_ADDR;
                    nxt_sl_tmr = TIMER_BITS'(ALE_OPEN_CYC - 1);
                end
            end
            SL_ADDR: begin
                if (sl_tmr_0) begin
                    nxt_sl = SL_DATA;
                end
            end
            SL_DATA: begin
                if (!net_ready_n_in) begin
                    nxt_sl = SL_DONE;
                end
            end
            SL_DONE: begin
                nxt_sl = SL_IDLE;
            end
            default: begin
                nxt_sl = SL_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset || lan_rst) begin
            sl_ff     <= SL_IDLE;
            sl_tmr_ff <= '0;
        end else begin
            sl_ff     <= nxt_sl;
            sl_tmr_ff <= nxt_sl_tmr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sl_cmd_ff <= '0;
        end else if (sl_take) begin
            sl_cmd_ff <= ctl_cmd;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctl_rdata_ff <= BUS_ZERO;
        end else if (sl_ff == SL_DATA && !net_ready_n_in && !sl_cmd_ff.wr) begin
            ctl_rdata_ff <= lad_in;
        end
    end

    // one output register serves both directions of the local bus
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lad_ff <= BUS_ZERO;
        end else if (sl_take) begin
            lad_ff <= ctl_cmd.addr;
        end else if (sl_ff == SL_ADDR && sl_tmr_0) begin
            lad_ff <= sl_cmd_ff.data;
        end else if (sr_rd_last && owner_net_ff) begin
            lad_ff <= sram_ad_in;
        end
    end

    assign ctl_ack   = (sl_ff == SL_DONE);
    assign ctl_rdata = ctl_rdata_ff;

    wire dev_master = !grant_ff && !lan_off;
    wire sl_wr_data = sl_cmd_ff.wr && (sl_ff == SL_DATA);
    wire net_rd_out = grant_ff && net_rdy_ff && net_rd_ff && !net_bus_drive_en_n_in;

    assign lad_out  = lad_ff;
    assign lad_oe_n = !((dev_master && ((sl_ff == SL_ADDR) || sl_wr_data)) || net_rd_out);

    assign net_read_out  = !sl_cmd_ff.wr;
    assign net_read_oe_n = !dev_master;

    assign controller_data_strobe_n_out  = !(sl_ff == SL_DATA);
    assign controller_data_strobe_n_oe_n = !dev_master;

    assign net_bus_drive_en_n_out  = !sl_wr_data;
    assign net_bus_drive_en_n_oe_n = !dev_master;

    assign net_ready_n_out  = !net_rdy_ff;
    assign net_ready_n_oe_n = !grant_ff;

    assign net_bus_grant_n = !grant_ff;
    assign net_reset_n     = !lan_rst;
    assign thin_lan        = straps.thin_lan;
    assign lan_enabled     = straps.lan_enabled;
    assign straps_valid    = straps.valid;

endmodule

/* verif/lsb_shared_bus_checker.sv */
// pin assertions for the shared sram bus arbiter
`timescale 1ns/1ns
module lsb_shared_bus_checker (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic host_req,
    input wire logic sram_write_n,
    input wire logic sram_output_en_n,
    input wire logic sram_addr_latch_en,
    input wire logic sram_sel_upper_n,
    input wire logic sram_sel_lower_n,
    input wire logic net_byte_mask_hi_n,
    input wire logic net_byte_mask_lo_n,
    input wire logic net_bus_request_n,
    input wire logic net_bus_grant_n,
    input wire logic net_reset_n,
    input wire logic [15:0] lad_in,
    input wire logic [15:0] sram_ad_out
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire strobe = !sram_write_n || !sram_output_en_n;
    wire [1:0] sel = {sram_sel_upper_n, sram_sel_lower_n};
    wire [1:0] mask = {net_byte_mask_hi_n, net_byte_mask_lo_n};
    // strobe low nine cycles, then released
    sequence low9_s(s);
        !s [*8] ##1 !s ##1 s;
    endsequence
    sequence held_s;
        !net_bus_grant_n && !net_bus_request_n && net_reset_n;
    endsequence
    one_strobe_a: assert property (sram_write_n || sram_output_en_n) else $error("strobes");
    latch_held_a: assert property (strobe |-> !sram_addr_latch_en) else $error("ale");
    write_len_a: assert property ($fell(sram_write_n) |-> low9_s(sram_write_n)) else $error("wr");
    read_len_a: assert property ($fell(sram_output_en_n) |-> low9_s(sram_output_en_n)) else $error("rd");
    grant_hold_a: assert property (held_s |=> !net_bus_grant_n) else $error("grant lost");
    grant_cause_a: assert property (net_bus_request_n [*2] |-> net_bus_grant_n) else $error("grant");
    mask_sel_a: assert property (!host_req && strobe |-> sel == mask) else $error("sel");
    ctl_reset_a: assert property (disable iff (1'b0) reset [*2] |-> !net_reset_n) else $error("rst");
    net_addr_a: assert property ($rose(sram_addr_latch_en) && !net_bus_grant_n |->
        sram_ad_out == {3'h0, lad_in[12:0]}) else $error("addr");
endmodule
bind lsb_shared_bus lsb_shared_bus_checker lsb_shared_bus_checker_inst (.*);

/* verif/lsb_net_model.sv */
// controller model: one sram write then one read as master, ready as slave
`timescale 1ns/1ns
module lsb_net_model (
    input wire logic core_clk,
    input wire logic net_go,
    input wire logic net_bus_grant_n,
    input wire logic net_ready_n_out,
    input wire logic controller_data_strobe_n_out,
    output logic     net_bus_request_n = 1,
    output logic     net_addr_latch_en = 1,
    output logic     net_byte_mask_hi_n = 1,
    output logic     net_byte_mask_lo_n = 1,
    output logic     net_read_in = 0,
    output logic     net_bus_drive_en_n_in = 1,
    output logic     net_ready_n_in = 1
);
    // as slave, ready answers the data strobe half a cycle later, at the next falling clock edge
    always @(negedge core_clk) net_ready_n_in <= controller_data_strobe_n_out;
    // ale high from power-up keeps the lan section on; first pass writes
    always @(posedge net_go) begin
        @(negedge core_clk) net_bus_request_n <= 0;
        repeat (40) if (net_bus_grant_n) @(negedge core_clk);
        repeat (2) begin
            // ale stays high a few cycles so the granted latch takes the address
            repeat (4) @(negedge core_clk);
            net_addr_latch_en <= 0;
            net_byte_mask_hi_n <= 0;
            net_bus_drive_en_n_in <= !net_read_in;
            repeat (40) if (net_ready_n_out) @(negedge core_clk);
            @(negedge core_clk) net_addr_latch_en <= 1;
            net_byte_mask_hi_n <= 1;
            net_bus_drive_en_n_in <= 1;
            net_read_in <= 1;
        end
        net_bus_request_n <= 1;
    end
endmodule

/* verif/lsb_shared_bus_tb_top.sv */
// self-checking bench for the shared sram bus arbiter
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module lsb_shared_bus_tb_top import lsb_pkg::*;;
    logic core_clk = 0, reset = 1, backplane_reset = 0, lan_reg1_wr = 0, host_req = 0;
    logic ctl_req = 0, irq_enable = 0, sram_sel_upper_in = 1, net_irq_n = 1, net_go = 0;
    logic controller_data_strobe_n_in = 1, net_bus_drive_en_n_in, net_ready_n_in, sd_d = 1;
    logic host_ack, ctl_ack, net_irq_status, thin_lan, lan_enabled, straps_valid;
    logic sram_ad_oe_n, sram_sel_upper_n, sram_sel_upper_oe_n, sram_sel_lower_n, wr_d = 1;
    logic sram_write_n, sram_output_en_n, sram_addr_latch_en, net_reset_n, net_bus_grant_n;
    logic lad_oe_n, net_read_out, net_read_oe_n, net_bus_request_n, net_addr_latch_en;
    logic net_byte_mask_hi_n, net_byte_mask_lo_n, net_read_in, controller_data_strobe_n_out;
    logic controller_data_strobe_n_oe_n, net_bus_drive_en_n_out, net_bus_drive_en_n_oe_n;
    logic net_ready_n_out, net_ready_n_oe_n, rdy_d = 1;
    logic [1:0] irq_level = 0;
    logic [3:0] host_irq_n;
    logic [15:0] host_rdata, ctl_rdata, sram_ad_in = 0, sram_ad_out, lad_in = 0, lad_out, e, g;
    lsb_sram_req_type host_cmd = '0;
    lsb_ctl_req_type ctl_cmd = '0;
    logic [15:0] exp_q[$];
    int seed = 77, n_mismatch = 0, samples_checked = 0, n;
    lsb_shared_bus lsb_shared_bus_inst (.*);
    lsb_net_model lsb_net_model_inst (.*);
    always #4 core_clk = ~core_clk;
    task automatic conclude();
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic host_op(input logic wr);
        @(negedge core_clk);
        sram_ad_in = 16'($random(seed));
        exp_q.push_back(sram_ad_in);
        host_cmd = '{wr, 1'b0, sram_ad_in[0], sram_ad_in[12:0], sram_ad_in};
        host_req = 1;
        for (n = 0; n < 40 && !host_ack; n++)
            @(negedge core_clk);
        host_req = 0;
    endtask
    task automatic ctl_op(input logic wr);
        @(negedge core_clk);
        lad_in = 16'($random(seed));
        exp_q.push_back(lad_in);
        ctl_cmd = '{wr, ~lad_in, lad_in};
        ctl_req = 1;
        for (n = 0; n < 40 && !ctl_ack; n++)
            @(negedge core_clk);
        ctl_req = 0;
    endtask
    // reads compare at ack, writes as the sram write strobe or the controller data strobe falls
    always @(posedge core_clk) begin
        wr_d <= sram_write_n;
        sd_d <= controller_data_strobe_n_out;
        rdy_d <= net_ready_n_out;
        if ((host_ack && !host_cmd.wr) || (wr_d && !sram_write_n)) begin
            e = exp_q.pop_front();
            `CHK(host_ack ? host_rdata : sram_ad_out, e)
        end
        if ((ctl_ack && !ctl_cmd.wr) ||
            (sd_d && !controller_data_strobe_n_out && ctl_cmd.wr)) begin
            e = exp_q.pop_front();
            g = ctl_cmd.wr ? lad_out : ctl_rdata;
            `CHK({net_read_out, lad_oe_n, g}, {{2{!ctl_cmd.wr}}, e})
        end
        // controller read: data on the local bus as ready first goes low
        if (rdy_d && !net_ready_n_out && net_read_in) begin
            e = exp_q.pop_front();
            `CHK({lad_oe_n, lad_out}, {1'b0, e})
        end
    end
    initial begin
        #40000;
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (12) @(negedge core_clk);
        reset = 0;
        for (n = 0; n < 300 && !net_reset_n; n++)
            @(negedge core_clk);
        `CHK({straps_valid, thin_lan, lan_enabled}, 3'h7)
        host_op(1);
        host_op(0);
        irq_level = 2'($random(seed));
        irq_enable = 1;
        net_irq_n = 0;
        @(negedge core_clk);
        `CHK({net_irq_status, host_irq_n}, {1'b1, ~(4'h1 << irq_level)})
        net_irq_n = 1;
        for (int k = 1; k < 3; k++) begin
            {backplane_reset, lan_reg1_wr} = 2'(k);
            @(negedge core_clk) {backplane_reset, lan_reg1_wr} = 2'b00;
            @(negedge core_clk) `CHK(net_reset_n, 1'b0)
            for (n = 0; n < 300 && !net_reset_n; n++)
                @(negedge core_clk);
        end
        ctl_op(1);
        ctl_op(0);
        lad_in = 16'($random(seed));
        sram_ad_in = 16'($random(seed));
        exp_q.push_back(lad_in);
        exp_q.push_back(sram_ad_in);
        net_go = 1;
        repeat (2) @(negedge core_clk);
        for (n = 0; n < 120 && !net_bus_request_n; n++)
            @(negedge core_clk);
        @(negedge core_clk) `CHK(net_bus_grant_n, 1'b1)
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule
